// ---- logic/crx_defs.vh ----
// Purpose: constants for the can receive filter / buffer / debug block
// Assumes: apb with 32-bit data, byte addresses
// Notes:   none
`ifndef CRX_DEFS_VH
`define CRX_DEFS_VH
// ==========================================================
// register offsets
`define CRX_OFS_NDAT_LO   12'h000
`define CRX_OFS_NDAT_HI   12'h004
`define CRX_OFS_CTRL      12'h008
`define CRX_OFS_STATUS    12'h00c
`define CRX_OFS_FLT_IDX   12'h010
`define CRX_OFS_FLT_DATA  12'h014
`define CRX_OFS_TEV       12'h018
// ==========================================================
// filter element fields
`define CRX_SFT_HI        31
`define CRX_SFT_LO        30
`define CRX_STD_ELEMENT_CONFIG_HI       29
`define CRX_STD_ELEMENT_CONFIG_LO       27
`define CRX_ID1_HI        26
`define CRX_ID1_LO        16
`define CRX_ID2_HI        10
`define CRX_ID2_LO        0
`define CRX_SFT_RANGE     2'h0
`define CRX_SFT_DUAL      2'h1
`define CRX_SFT_CLASSIC   2'h2
`define CRX_EC_DISABLE    3'h0
`define CRX_EC_REJECT     3'h3
`define CRX_EC_BUFFER     3'h7
`define CRX_NUM_FLT       128
// ==========================================================
// event element fields
`define CRX_ET_TXE        2'h1
`define CRX_ET_TXC        2'h2
`define CRX_EV_FDF        21
`define CRX_EV_BRS        20
// ==========================================================
// debug status codes
`define CRX_DMS_IDLE      2'h0
`define CRX_DMS_A         2'h1
`define CRX_DMS_AB        2'h2
`define CRX_DMS_ABC       2'h3
`endif

// ---- logic/crx_rx_filter.v ----
// Purpose: can receive acceptance filter, rx buffer new-data flags, debug message capture, tx event word
// Assumes: protocol engine hands one received id at a time; message ram writer reports the last word
// Notes:   filter list is held locally, one element per cycle is scanned
//          register map, byte offsets:
//            0x00 new-data flags 31:0, write one to clear
//            0x04 new-data flags 63:32, write one to clear
//            0x08 control: 7:0 element count (max 128), 8 reject non-matching
//            0x0c status: 0 irq flag (write one clears), 3:2 debug status,
//                 4 dma request, 5 filter busy
//            0x10 filter element index
//            0x14 filter element at index
//            0x18 tx event word
//          apb answers with no wait state; refused offsets raise pslverr
`timescale 1ns/10ps
`include "crx_defs.vh"
module crx_rx_filter (
    // apb slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // received frame from protocol engine
    input  wire        rx_valid,
    input  wire [10:0] rx_id,
    // message ram store handshake
    output reg         store_req,
    output reg  [5:0]  store_buf,
    output reg         store_fifo,
    input  wire        store_last_word,
    // debug dma
    output reg         dbg_dma_req,
    input  wire        dbg_dma_ack,
    // tx event inputs
    input  wire        tev_valid,
    input  wire        tev_cancelled,
    input  wire        tev_fd,
    input  wire        tev_brs,
    input  wire [3:0]  tev_dlc,
    input  wire [15:0] tev_ts,
    // status
    output reg         buffer_received_irq_flag,
    output reg  [1:0]  debug_message_status,
    output reg  [6:0]  tev_bytes,
    output reg         filter_busy
);

// ==========================================================
// state
localparam ST_IDLE  = 2'h0;
localparam ST_SCAN  = 2'h1;
localparam ST_STORE = 2'h2;

// filter list and flags
reg [31:0] flt_mem [0:`CRX_NUM_FLT-1];
reg [31:0] new_data_flags_low;
reg [31:0] new_data_flags_high;

// scan state
reg [1:0]  state_r;
reg [6:0]  idx_r;
reg [10:0] id_r;
reg [6:0]  flt_idx_r;
reg [7:0]  flt_cnt_r;
reg        nm_reject_r;

// debug and event
reg        dbg_store_r;
reg [1:0]  dbg_step_r;
reg [31:0] tev_word_r;
reg [31:0] rdata_nxt;

wire        acc      = psel & penable;
wire        wr       = acc & pwrite;
wire [31:0] elem     = flt_mem[idx_r];
wire [1:0]  std_filter_type      = elem[`CRX_SFT_HI:`CRX_SFT_LO];
wire [2:0]  std_element_config = elem[`CRX_STD_ELEMENT_CONFIG_HI:`CRX_STD_ELEMENT_CONFIG_LO];
wire [10:0] std_first_id  = elem[`CRX_ID1_HI:`CRX_ID1_LO];
wire [10:0] std_second_id = elem[`CRX_ID2_HI:`CRX_ID2_LO];
wire [5:0]  tgt      = std_second_id[5:0];
wire [63:0] nd_all   = {new_data_flags_high, new_data_flags_low};
wire        is_dbg   = (std_element_config == `CRX_EC_BUFFER);
wire        last_idx = ({1'b0, idx_r} + 8'h01 >= flt_cnt_r);

// ==========================================================
// id compare
// filter types
reg id_hit;
always @* begin
    case (std_filter_type)
        `CRX_SFT_RANGE:   id_hit = (id_r >= std_first_id) && (id_r <= std_second_id);
        `CRX_SFT_DUAL:    id_hit = (id_r == std_first_id) || (id_r == std_second_id);
        `CRX_SFT_CLASSIC: id_hit = ((id_r ^ std_first_id) & std_second_id) == 11'h000;
        default:          id_hit = 1'b0;
    endcase
end

reg elem_match;
always @* begin
    elem_match = 1'b0;
    if (std_element_config != `CRX_EC_DISABLE && id_hit) begin
        if (is_dbg) begin
            elem_match = ~dbg_dma_req & ~nd_all[tgt];
        end else begin
            elem_match = 1'b1;
        end
    end
end

// ==========================================================
// control
// ascending scan, first match
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state_r     <= ST_IDLE;
        idx_r       <= 7'h00;
        id_r        <= 11'h000;
        store_req   <= 1'b0;
        store_buf   <= 6'h00;
        store_fifo  <= 1'b0;
        dbg_store_r <= 1'b0;
        dbg_step_r  <= 2'h0;
        filter_busy <= 1'b0;
    end else begin
        case (state_r)
            ST_IDLE: begin
                if (rx_valid) begin
                    id_r        <= rx_id;
                    idx_r       <= 7'h00;
                    filter_busy <= 1'b1;
                    if (flt_cnt_r == 8'h00) begin
                        // empty list: go straight to the non-matching policy
                        state_r   <= ST_STORE;
                        store_req <= !nm_reject_r;
                    end else begin
                        state_r   <= ST_SCAN;
                        store_req <= 1'b0;
                    end
                    store_fifo  <= 1'b1;
                    dbg_store_r <= 1'b0;
                end
            end
            ST_SCAN: begin
                if (elem_match) begin
                    store_req   <= (std_element_config != `CRX_EC_REJECT);
                    store_buf   <= tgt;
                    store_fifo  <= (std_element_config != `CRX_EC_BUFFER);
                    dbg_store_r <= is_dbg & (std_second_id[10:9] != 2'h0);
                    dbg_step_r  <= std_second_id[10:9];
                    state_r     <= ST_STORE;
                end else if (last_idx) begin
                    store_req  <= !nm_reject_r;
                    store_fifo <= 1'b1;
                    state_r    <= ST_STORE;
                end else begin
                    idx_r <= idx_r + 7'h01;
                end
            end
            ST_STORE: begin
                // a rejected frame has no store request and frees the filter at once
                if (!store_req || store_last_word) begin
                    store_req   <= 1'b0;
                    filter_busy <= 1'b0;
                    state_r     <= ST_IDLE;
                end
            end
            default: state_r <= ST_IDLE;
        endcase
    end
end

// a store counts only once the ram writer reports its last word
wire stored = (state_r == ST_STORE) && store_req && store_last_word;

// ==========================================================
// new data flags, debug status, dma request
// apb write strobes, one per writable register; the write lands in the access phase
wire wr_ndat_lo  = wr && (paddr == `CRX_OFS_NDAT_LO);
wire wr_ndat_hi  = wr && (paddr == `CRX_OFS_NDAT_HI);
wire wr_status   = wr && (paddr == `CRX_OFS_STATUS);
wire wr_ctrl     = wr && (paddr == `CRX_OFS_CTRL);
wire wr_flt_idx  = wr && (paddr == `CRX_OFS_FLT_IDX);
wire wr_flt_data = wr && (paddr == `CRX_OFS_FLT_DATA);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        new_data_flags_low       <= 32'h0000_0000;
        new_data_flags_high      <= 32'h0000_0000;
        buffer_received_irq_flag <= 1'b0;
        debug_message_status     <= `CRX_DMS_IDLE;
        dbg_dma_req              <= 1'b0;
    end else begin
        if (wr_ndat_lo) begin
            new_data_flags_low <= new_data_flags_low & ~pwdata;
        end
        if (wr_ndat_hi) begin
            new_data_flags_high <= new_data_flags_high & ~pwdata;
        end
        if (wr_status && pwdata[0]) begin
            buffer_received_irq_flag <= 1'b0;
        end
        // set after last word, set wins over clear
        if (stored && !store_fifo && !dbg_store_r) begin
            if (store_buf[5])
                new_data_flags_high[store_buf[4:0]] <= 1'b1;
            else
                new_data_flags_low[store_buf[4:0]] <= 1'b1;
            buffer_received_irq_flag <= 1'b1;
        end
        if (stored && dbg_store_r) begin
            debug_message_status <= dbg_step_r;
            if (dbg_step_r == `CRX_DMS_ABC) begin
                dbg_dma_req <= 1'b1;
            end
        end
        if (dbg_dma_req && dbg_dma_ack) begin
            dbg_dma_req          <= 1'b0;
            debug_message_status <= `CRX_DMS_IDLE;
        end
    end
end

// ==========================================================
// control register and filter list
// 128 elements, addressed by the index register alone
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        flt_idx_r   <= 7'h00;
        flt_cnt_r   <= 8'h00;
        nm_reject_r <= 1'b0;
    end else begin
        // a count above 128 is clamped so the scan never leaves the list
        if (wr_ctrl) begin
            flt_cnt_r   <= (pwdata[7:0] > 8'h80) ? 8'h80 : pwdata[7:0];
            nm_reject_r <= pwdata[8];
        end
        if (wr_flt_idx) begin
            flt_idx_r <= pwdata[6:0];
        end
    end
end

// memory has no reset: software loads the list before enabling filtering
always @(posedge pclk) begin
    if (wr_flt_data) begin
        flt_mem[flt_idx_r] <= pwdata;
    end
end

// ==========================================================
// tx event element
// length code to bytes
reg [6:0] bytes_nxt;
always @* begin
    if (tev_dlc <= 4'h8) begin
        bytes_nxt = {3'h0, tev_dlc};
    end else if (!tev_fd) begin
        // classical frames saturate at eight bytes
        bytes_nxt = 7'h08;
    end else begin
        case (tev_dlc)
            4'h9:    bytes_nxt = 7'h0c;
            4'ha:    bytes_nxt = 7'h10;
            4'hb:    bytes_nxt = 7'h14;
            4'hc:    bytes_nxt = 7'h18;
            4'hd:    bytes_nxt = 7'h20;
            4'he:    bytes_nxt = 7'h30;
            default: bytes_nxt = 7'h40;
        endcase
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        tev_word_r <= 32'h0000_0000;
        tev_bytes  <= 7'h00;
    end else if (tev_valid) begin
        // event type code
        // reserved codes 0 and 3 are never produced
        tev_word_r[23:22] <= tev_cancelled ? `CRX_ET_TXC : `CRX_ET_TXE;
        tev_word_r[`CRX_EV_FDF] <= tev_fd;
        tev_word_r[`CRX_EV_BRS] <= tev_brs;
        tev_word_r[19:16] <= tev_dlc;
        tev_word_r[15:0]  <= tev_ts;
        tev_word_r[31:24] <= 8'h00;
        tev_bytes <= bytes_nxt;
    end
end

// ==========================================================
// apb read and answer
always @* begin
    case (paddr)
        `CRX_OFS_NDAT_LO:  rdata_nxt = new_data_flags_low;
        `CRX_OFS_NDAT_HI:  rdata_nxt = new_data_flags_high;
        `CRX_OFS_CTRL:     rdata_nxt = {23'h0, nm_reject_r, flt_cnt_r};
        `CRX_OFS_STATUS:   rdata_nxt = {26'h0, filter_busy, dbg_dma_req, debug_message_status,
                                        1'b0, buffer_received_irq_flag};
        `CRX_OFS_FLT_IDX:  rdata_nxt = {25'h0, flt_idx_r};
        `CRX_OFS_FLT_DATA: rdata_nxt = flt_mem[flt_idx_r];
        `CRX_OFS_TEV:      rdata_nxt = tev_word_r;
        default:           rdata_nxt = 32'h0000_0000;
    endcase
end

// misaligned or unmapped offsets are refused
wire bad_addr = (paddr > `CRX_OFS_TEV) || (paddr[1:0] != 2'h0);

// no wait state: ready is registered in the setup cycle and stands in the first access cycle
// prdata is refreshed every cycle; only the beat with pready counts
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata  <= 32'h0000_0000;
        pready  <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready  <= psel & ~penable;
        prdata  <= rdata_nxt;
        pslverr <= psel & ~penable & bad_addr;
    end
end

endmodule // crx_rx_filter

// ---- dv/crx_rx_filter_sva.sv ----
// Purpose: port assertions for crx_rx_filter
// Assumes: one pclk domain, async active-low reset
// Notes:   debug status is judged only where the dma request rises
`timescale 1ns/10ps
module crx_rx_filter_sva (
    // clock and reset
    input wire       pclk,
    input wire       presetn,
    // apb
    input wire       psel,
    input wire       penable,
    input wire       pready,
    input wire       pslverr,
    // receive and store
    input wire       rx_valid,
    input wire       filter_busy,
    input wire       store_req,
    input wire [5:0] store_buf,
    input wire       store_last_word,
    // debug
    input wire       dbg_dma_req,
    input wire       dbg_dma_ack,
    input wire [1:0] debug_message_status
);
// ==========================================
// assertions
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
property p_apb_ans; psel && !penable |=> pready && psel && penable; endproperty
a_apb_ans: assert property (p_apb_ans) else $error("apb answer late");
property p_apb_pulse; pready |=> !pready; endproperty
a_apb_pulse: assert property (p_apb_pulse) else $error("pready stands too long");
property p_err_ready; pslverr |-> pready; endproperty
a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
property p_store_hold; store_req && !store_last_word |=> store_req && $stable(store_buf); endproperty
a_store_hold: assert property (p_store_hold) else $error("store dropped early");
property p_take; rx_valid && !filter_busy |=> filter_busy; endproperty
a_take: assert property (p_take) else $error("frame not taken");
property p_scan; $rose(filter_busy) |-> ##[0:130] (store_req || !filter_busy); endproperty
a_scan: assert property (p_scan) else $error("scan too long");
property p_dma_c; $rose(dbg_dma_req) |-> debug_message_status == 2'h3; endproperty
a_dma_c: assert property (p_dma_c) else $error("dma request before third");
property p_dma_hold; dbg_dma_req && !dbg_dma_ack |=> dbg_dma_req; endproperty
a_dma_hold: assert property (p_dma_hold) else $error("dma request lost");
property p_dma_ack; dbg_dma_req && dbg_dma_ack |=> !dbg_dma_req; endproperty
a_dma_ack: assert property (p_dma_ack) else $error("dma request stuck");
endmodule // crx_rx_filter_sva
bind crx_rx_filter crx_rx_filter_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .filter_busy(filter_busy), .store_req(store_req),
    .store_buf(store_buf), .store_last_word(store_last_word), .dbg_dma_req(dbg_dma_req),
    .dbg_dma_ack(dbg_dma_ack), .debug_message_status(debug_message_status));

// ---- dv/crx_ram_model.sv ----
// Purpose: message ram writer and dma unit facing the filter
// Assumes: one store or one dma read in flight
// Notes:   slow stretches both waits, the dma one past a full rx scan
`timescale 1ns/10ps
module crx_ram_model (
    // clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // pacing
    input  wire       slow,
    // store side
    input  wire       store_req,
    input  wire [5:0] store_buf,
    input  wire       store_fifo,
    output reg        store_last_word,
    // dma side
    input  wire       dbg_dma_req,
    output reg        dbg_dma_ack,
    // observation
    output reg  [7:0] n_st,
    output reg  [5:0] l_buf,
    output reg        l_fifo
);
reg [8:0] st_cnt;
reg [8:0] dma_cnt;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        {store_last_word, dbg_dma_ack, n_st, l_buf, l_fifo, st_cnt, dma_cnt} <= 0;
    end else begin
        store_last_word <= 1'b0;
        dbg_dma_ack     <= 1'b0;
        // last word after the element is written
        if (store_req && !store_last_word) begin
            st_cnt <= st_cnt + 9'h1;
            if (st_cnt >= (slow ? 9'h9 : 9'h1)) begin
                {store_last_word, st_cnt} <= {1'b1, 9'h0};
                {n_st, l_buf, l_fifo}     <= {n_st + 8'h1, store_buf, store_fifo};
            end
        end
        // acknowledge once the three words are read
        if (dbg_dma_req && !dbg_dma_ack) begin
            dma_cnt <= dma_cnt + 9'h1;
            if (dma_cnt >= (slow ? 9'h12c : 9'h2))
                {dbg_dma_ack, dma_cnt} <= {1'b1, 9'h0};
        end
    end
end
endmodule // crx_ram_model

// ---- dv/tb_crx_rx_filter.sv ----
// Purpose: self-checking bench for crx_rx_filter
// Assumes: apb answers in one access cycle, ram model on the store side
// Notes:   ids are chosen so no element matches by accident
`timescale 1ns/10ps
`include "crx_defs.vh"
module tb_crx_rx_filter;
reg pclk, presetn, psel, penable, pwrite, rx_valid, tev_valid, tev_cancelled, tev_fd, tev_brs, slow;
reg  [11:0] paddr;
reg  [31:0] pwdata, r;
reg  [10:0] rx_id;
reg  [3:0]  tev_dlc;
reg  [15:0] tev_ts;
wire [31:0] prdata;
wire [6:0]  tev_bytes;
wire [5:0]  store_buf, l_buf;
wire [7:0]  n_st;
wire [1:0]  debug_message_status;
wire pready, pslverr, store_req, store_fifo, store_last_word, dbg_dma_req, dbg_dma_ack;
wire buffer_received_irq_flag, filter_busy, l_fifo;
reg er;
integer fail_count, total_checks, i;
crx_rx_filter i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
    .rx_id(rx_id), .store_req(store_req), .store_buf(store_buf), .store_fifo(store_fifo),
    .store_last_word(store_last_word), .dbg_dma_req(dbg_dma_req), .dbg_dma_ack(dbg_dma_ack),
    .tev_valid(tev_valid), .tev_cancelled(tev_cancelled), .tev_fd(tev_fd), .tev_brs(tev_brs),
    .tev_dlc(tev_dlc), .tev_ts(tev_ts), .buffer_received_irq_flag(buffer_received_irq_flag),
    .debug_message_status(debug_message_status), .tev_bytes(tev_bytes), .filter_busy(filter_busy));
crx_ram_model i_ram (.pclk(pclk), .presetn(presetn), .slow(slow), .store_req(store_req),
    .store_buf(store_buf), .store_fifo(store_fifo), .store_last_word(store_last_word),
    .dbg_dma_req(dbg_dma_req), .dbg_dma_ack(dbg_dma_ack), .n_st(n_st), .l_buf(l_buf), .l_fifo(l_fifo));
// ==========================================
// shared tasks
task chk(input [31:0] g, input [31:0] e);
    begin
        total_checks = total_checks + 1;
        if (g !== e) begin
            fail_count = fail_count + 1;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    end
endtask
task apb(input w, input [11:0] a, input [31:0] d);
    integer k;
    begin
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk) penable <= 1'b1;
        for (k = 0; k < 20 && pready !== 1'b1; k = k + 1) @(posedge pclk);
        if (pready !== 1'b1) begin
            fail_count = fail_count + 1;
            $display("ERROR %0t apb answer missing", $time);
        end
        {r, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    end
endtask
task rd(input [11:0] a, input [31:0] e);
    begin apb(1'b0, a, 32'h0); chk(r, e); end
endtask
task rx(input [10:0] id, input st, input [5:0] eb, input ef);
    integer k;
    reg [7:0] n0;
    begin
        n0 = n_st;
        for (k = 0; k < 200 && filter_busy !== 1'b0; k = k + 1) @(posedge pclk);
        {rx_valid, rx_id} <= {1'b1, id};
        @(posedge pclk) rx_valid <= 1'b0;
        // busy is raised at the taking edge, so look one edge later
        @(posedge pclk);
        for (k = 0; k < 400 && filter_busy !== 1'b0; k = k + 1) @(posedge pclk);
        chk(n_st - n0, st);
        if (st) chk(ef ? l_fifo : {l_fifo, l_buf}, ef ? 1'b1 : {1'b0, eb});
    end
endtask
function [31:0] fe(input [1:0] t, input [2:0] c, input [10:0] a, input [10:0] b);
    fe = {t, c, a, 5'h00, b};
endfunction
function [6:0] nb(input [3:0] d, input f);
    case (d)
        4'h9: nb = f ? 7'h0c : 7'h08;
        4'ha: nb = f ? 7'h10 : 7'h08;
        4'hb: nb = f ? 7'h14 : 7'h08;
        4'hc: nb = f ? 7'h18 : 7'h08;
        4'hd: nb = f ? 7'h20 : 7'h08;
        4'he: nb = f ? 7'h30 : 7'h08;
        4'hf: nb = f ? 7'h40 : 7'h08;
        default: nb = {3'h0, d};
    endcase
endfunction
// ==========================================
// scenarios
task t_regs;
    begin
        rd(`CRX_OFS_NDAT_LO, 0); rd(`CRX_OFS_NDAT_HI, 0); rd(`CRX_OFS_STATUS, 0);
        apb(1'b0, 12'h01c, 0); chk(er, 1); apb(1'b0, 12'h002, 0); chk(er, 1);
        apb(1'b1, `CRX_OFS_CTRL, 32'h1ff); rd(`CRX_OFS_CTRL, 32'h180);
    end
endtask
task t_filter;
    begin
        apb(1'b1, `CRX_OFS_CTRL, 32'h103);
        apb(1'b1, `CRX_OFS_FLT_IDX, 0); apb(1'b1, `CRX_OFS_FLT_DATA, fe(1, 7, 11'h123, 11'h005));
        apb(1'b1, `CRX_OFS_FLT_IDX, 1); apb(1'b1, `CRX_OFS_FLT_DATA, fe(0, 1, 11'h100, 11'h1ff));
        apb(1'b1, `CRX_OFS_FLT_IDX, 2); apb(1'b1, `CRX_OFS_FLT_DATA, fe(2, 1, 11'h300, 11'h700));
        rx(11'h123, 1, 5, 0); rd(`CRX_OFS_NDAT_LO, 32'h20); chk(buffer_received_irq_flag, 1);
        rx(11'h123, 1, 0, 1); rx(11'h1ff, 1, 0, 1); rx(11'h3ab, 1, 0, 1); rx(11'h0ff, 0, 0, 0);
        apb(1'b1, `CRX_OFS_STATUS, 1); chk(buffer_received_irq_flag, 0);
        apb(1'b1, `CRX_OFS_NDAT_LO, 0); rd(`CRX_OFS_NDAT_LO, 32'h20);
        apb(1'b1, `CRX_OFS_NDAT_LO, 32'h20); rd(`CRX_OFS_NDAT_LO, 0);
        rx(11'h123, 1, 5, 0); apb(1'b1, `CRX_OFS_STATUS, 1);
    end
endtask
task t_debug;
    integer k;
    begin
        apb(1'b1, `CRX_OFS_CTRL, 32'h106);
        for (k = 0; k < 3; k = k + 1) begin
            apb(1'b1, `CRX_OFS_FLT_IDX, 3 + k);
            apb(1'b1, `CRX_OFS_FLT_DATA, fe(1, 7, 11'h401 + k, {k[1:0] + 2'h1, 3'h0, 6'd61 + k[5:0]}));
        end
        slow <= 1'b1;
        for (k = 0; k < 3; k = k + 1) begin
            rx(11'h401 + k, 1, 6'd61 + k[5:0], 0); chk(debug_message_status, k + 1);
        end
        repeat (2) @(posedge pclk);
        chk(dbg_dma_req, 1); chk(buffer_received_irq_flag, 0); rd(`CRX_OFS_NDAT_HI, 0);
        rx(11'h401, 0, 0, 0);
        for (k = 0; k < 400 && dbg_dma_req !== 1'b0; k = k + 1) @(posedge pclk);
        chk(dbg_dma_req, 0); chk(debug_message_status, 0); rx(11'h401, 1, 61, 0);
    end
endtask
task t_tev;
    reg [4:0] k;
    begin
        for (i = 0; i < 32; i = i + 1) begin
            k = i[4:0];
            {tev_valid, tev_dlc, tev_fd, tev_brs, tev_cancelled} <= {1'b1, k[3:0], k[4], k[1], k[0]};
            tev_ts <= 16'ha5c3 ^ {11'h0, k};
            @(posedge pclk) tev_valid <= 1'b0;
            @(posedge pclk);
            rd(`CRX_OFS_TEV, {8'h0, k[0] ? 2'h2 : 2'h1, k[4], k[1], k[3:0], 16'ha5c3 ^ {11'h0, k}});
            chk(tev_bytes, nb(k[3:0], k[4]));
        end
    end
endtask
task final_report;
    begin
        if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    end
endtask
// ==========================================
// clock, reset, sequence and watchdog
initial begin pclk = 1'b0; forever #2 pclk = ~pclk; end
initial begin
    {presetn, psel, penable, pwrite, rx_valid, tev_valid, tev_cancelled, tev_fd, tev_brs, slow} = 0;
    {paddr, pwdata, r, rx_id, tev_dlc, tev_ts, er} = 0;
    {fail_count, total_checks} = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs; t_filter; t_debug; t_tev;
    final_report;
end
initial begin #200000; fail_count = fail_count + 1; final_report; end
endmodule // tb_crx_rx_filter
